// File: src/udr_ep_regs.sv
module udr_ep_regs
  import udr_pkg::*;
#(
  parameter int NUM_EP = 5
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              flush,
  input  wire logic              we,
  input  wire logic [2:0]        wr_ep,
  input  wire logic [1:0]        wr_slot,
  input  wire logic [31:0]       wr_data,
  input  wire logic [3:0]        wr_strb,
  input  wire logic [2:0]        rd_ep,
  input  wire logic [1:0]        rd_slot,
  output logic      [31:0]       rd_data
);

  if (NUM_EP < 1 || NUM_EP > 8) begin : g_bad_num_ep
    $error("udr_ep_regs: NUM_EP out of range");
  end

  logic [31:0] mem_q [NUM_EP][4];
  logic [31:0] mem_d [NUM_EP][4];

  always_comb begin
    mem_d = mem_q;
    if (flush) begin
      for (int e = 0; e < NUM_EP; e++) begin
        for (int s = 0; s < 4; s++) begin
          mem_d[e][s] = 32'h0000_0000;
        end
      end
    end else if (we && int'(wr_ep) < NUM_EP) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) mem_d[wr_ep][wr_slot][8*b +: 8] = wr_data[8*b +: 8];
      end
      // R08 ep0 fifo fixed
      if (wr_ep == 3'h0) begin
        mem_d[0][3] = {3'h0, UDR_EP0_SIZE, 3'h0, UDR_EP0_START};
      end
    end
    if (NUM_EP > 0) mem_d[0][3] = {3'h0, UDR_EP0_SIZE, 3'h0, UDR_EP0_START};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int e = 0; e < NUM_EP; e++) begin
        for (int s = 0; s < 4; s++) begin
          mem_q[e][s] <= 32'h0000_0000;
        end
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rd_data = (int'(rd_ep) < NUM_EP) ? mem_q[rd_ep][rd_slot] : 32'h0000_0000;

endmodule : udr_ep_regs

// File: src/udr_link_ctrl.sv
// Operation
// R01 - one indexed endpoint register window selected by index register
// R02 - every endpoint also mapped flat, 16 bytes each, endpoint 0 first
// R03 - software sets clock select 0 for 24 MHz, 1 for 36 MHz
// R04 - polarity select 0 keeps data lines, 1 swaps them
// R05 - software powers phy up; clock-good set once pll locks
// R06 - vbus enable high as host in session, low as peripheral
// R07 - 4K fifo ram; per endpoint start, max size, double buffer
// R08 - only endpoints 1..4 placeable; endpoint 0 fixed 64 bytes at 0
// R09 - software keeps endpoint ram regions disjoint and large enough
// R10 - host mode on A end, peripheral mode on B end
// R11 - interrupt on transfer done, reset, resume, suspend, connect, sof
// R12 - handler services endpoint 0, then others, suspend last
// R13 - soft connect clears at reset; cleared means disconnected
// R14 - peripheral suspends after 3 ms idle, raising suspend interrupt
// R15 - external logic restarts stopped clock on resume signalling
// R16 - resume signalling exits suspend and raises resume interrupt
// R17 - software holds resume bit 2 to 15 ms for remote wakeup
// R18 - no resume interrupt for software-started wakeup
// R19 - bus reset zeroes address, index, fifos, csrs; raises reset interrupt
// R20 - high-speed enable during reset negotiates; outcome in active flag
// R21 - software closes pipes after reset interrupt
// R22 - vbus enable is a digital on/off output
// R23 - index holds until rewritten or bus reset
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
module udr_link_ctrl
  import udr_pkg::*;
#(
  parameter int SUSP_CYC = UDR_SUSP_CYC,
  parameter int NUM_EP   = 5
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cable_a_end,
  input  wire logic        session_valid,
  input  wire logic        bus_activity,
  input  wire logic        bus_resume,
  input  wire logic        bus_reset,
  input  wire logic        bus_connect,
  input  wire logic        bus_disconnect,
  input  wire logic        bus_sof,
  input  wire logic        hs_handshake_ok,
  input  wire logic [4:0]  ep_done,
  input  wire logic        pll_locked,
  output logic             vbus_supply_enable_output,
  output logic             pullup_enable,
  output logic             line_swap,
  output logic             host_mode,
  output logic             resume_drive,
  output logic             fifo_flush,
  output logic             usb_irq
);

  if (SUSP_CYC < 1) begin : g_bad_susp
    $error("udr_link_ctrl: SUSP_CYC must be positive");
  end
  if (NUM_EP != 5) begin : g_bad_num_ep
    $error("udr_link_ctrl: five endpoints expected");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [6:0]  fnadr_q, fnadr_d;
  logic [7:0]  power_q, power_d;
  logic [3:0]  index_q, index_d;
  logic [7:0]  phy_q, phy_d;
  logic [15:0] istat_q, istat_d;
  logic [15:0] ien_q, ien_d;
  logic [31:0] idle_q, idle_d;
  logic [4:0]  lock_q, lock_d;
  udr_phy_st_t pst_q, pst_d;
  logic        clkgd_q, clkgd_d;
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        vbus_q, vbus_d, pu_q, pu_d, swap_q, swap_d, host_q, host_d;
  logic        rsm_q, rsm_d, flush_q, flush_d, irq_q, irq_d;
  logic        bus_reset_q;
  logic        aw_rdy_q, aw_rdy_d, w_rdy_q, w_rdy_d, ar_rdy_q, ar_rdy_d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic ep_hit(input logic [11:0] a, output logic [2:0] ep,
                                  output logic [1:0] slot, input logic [3:0] idx);
    ep   = 3'h0;
    slot = a[3:2];
    // R01 indexed window
    if (a >= UDR_IDX_BASE && a <= UDR_IDX_LAST) begin
      ep = idx[2:0];
      return 1'b1;
    // R02 flat map
    end else if (a >= UDR_FLAT_BASE && a <= UDR_FLAT_LAST) begin
      ep = a[6:4];
      return 1'b1;
    end
    return 1'b0;
  endfunction : ep_hit

  logic        wr_fire, ep_we, rd_fire;
  logic [2:0]  wep, rep;
  logic [1:0]  wsl, rsl;
  logic        whit, rhit;
  logic [31:0] ep_rdata;

  always_comb begin
    whit = ep_hit(awa_q, wep, wsl, index_q);
    rhit = ep_hit(s_axi_araddr, rep, rsl, index_q);
  end

  assign wr_fire = aw_q && w_q && !bv_q;
  assign rd_fire = s_axi_arvalid && !rv_q;
  assign ep_we   = wr_fire && whit;

  // R07 fifo config bank
  udr_ep_regs #(.NUM_EP(NUM_EP)) u_ep (
    .aclk    (aclk),
    .aresetn (aresetn),
    .flush   (flush_d),
    .we      (ep_we),
    .wr_ep   (wep),
    .wr_slot (wsl),
    .wr_data (wd_q),
    .wr_strb (ws_q),
    .rd_ep   (rep),
    .rd_slot (rsl),
    .rd_data (ep_rdata)
  );

  // ----------------------------------------------------------------
  // bus slave and control
  // ----------------------------------------------------------------
  always_comb begin
    aw_d = aw_q; w_d = w_q; bv_d = bv_q; rv_d = rv_q;
    awa_d = awa_q; wd_d = wd_q; ws_d = ws_q; br_d = br_q; rr_d = rr_q; rd_d = rd_q;
    fnadr_d = fnadr_q; power_d = power_q; index_d = index_q; phy_d = phy_q;
    istat_d = istat_q; ien_d = ien_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = 2'b00;
      if (whit) begin
      end else if (awa_q == UDR_FNADR_OFF) begin
        if (ws_q[0]) fnadr_d = wd_q[6:0];
        if (ws_q[1]) begin
          // R13 soft connect
          power_d[UDR_PWR_SOFTC_BIT] = wd_q[8 + UDR_PWR_SOFTC_BIT];
          power_d[UDR_PWR_HSEN_BIT]  = wd_q[8 + UDR_PWR_HSEN_BIT];
          // R18 software resume
          power_d[UDR_PWR_RESUME_BIT] = wd_q[8 + UDR_PWR_RESUME_BIT];
        end
      end else if (awa_q == UDR_INTSTAT_OFF) begin
        // R23 index held
        if (ws_q[2]) index_d = wd_q[19:16];
      end else if (awa_q == UDR_INTEN_OFF) begin
        ien_d = wd_q[15:0];
      end else if (awa_q == UDR_PHYCTL_OFF) begin
        // R05 phy setup
        if (ws_q[0]) phy_d = wd_q[7:0];
      end else if (awa_q == UDR_STATUS_OFF) begin
        istat_d = istat_q & ~wd_q[15:0];
      end else begin
        br_d = 2'b10;
      end
    end
    if (rd_fire) begin
      rv_d = 1'b1;
      rr_d = 2'b00;
      if (rhit) rd_d = ep_rdata;
      else if (s_axi_araddr == UDR_FNADR_OFF) rd_d = {16'h0000, power_q, 1'b0, fnadr_q};
      else if (s_axi_araddr == UDR_INTSTAT_OFF) rd_d = {12'h000, index_q, 16'h0000};
      else if (s_axi_araddr == UDR_INTEN_OFF) rd_d = {16'h0000, ien_q};
      else if (s_axi_araddr == UDR_PHYCTL_OFF) rd_d = {23'h0, clkgd_q, phy_q};
      else if (s_axi_araddr == UDR_STATUS_OFF) rd_d = {14'h0, host_q, vbus_q, istat_q};
      else begin
        rd_d = 32'h0000_0000;
        rr_d = 2'b10;
      end
    end
    // R11 event flags, set beats clear
    if (bus_sof) istat_d[UDR_INT_SOF] = 1'b1;
    if (bus_connect) istat_d[UDR_INT_CONN] = 1'b1;
    if (bus_disconnect) istat_d[UDR_INT_DISCON] = 1'b1;
    for (int e = 0; e < 5; e++) begin
      if (ep_done[e]) istat_d[UDR_INT_EP0 + e] = 1'b1;
    end
    // R14 idle suspend
    if (!host_q && idle_q >= 32'(SUSP_CYC - 1) && !power_q[UDR_PWR_SUSPEND_BIT]
        && !bus_activity) begin
      power_d[UDR_PWR_SUSPEND_BIT] = 1'b1;
      if (ien_q[UDR_INT_SUSPEND]) istat_d[UDR_INT_SUSPEND] = 1'b1;
    end
    // R16 resume exits suspend
    if (power_q[UDR_PWR_SUSPEND_BIT] && bus_resume) begin
      power_d[UDR_PWR_SUSPEND_BIT] = 1'b0;
      // R18 no interrupt for own wakeup
      if (ien_q[UDR_INT_RESUME] && !power_q[UDR_PWR_RESUME_BIT])
        istat_d[UDR_INT_RESUME] = 1'b1;
    end
    // R19 bus reset
    if (bus_reset && !host_q) begin
      fnadr_d = 7'h00;
      index_d = 4'h0;
      power_d = power_q & 8'((1 << UDR_PWR_SOFTC_BIT) | (1 << UDR_PWR_HSEN_BIT));
      istat_d[UDR_INT_RESET] = 1'b1;
      // R20 hs negotiation
      power_d[UDR_PWR_HSACT_BIT] = power_q[UDR_PWR_HSEN_BIT] & hs_handshake_ok;
    end
  end

  // ----------------------------------------------------------------
  // phy start-up and pins
  // ----------------------------------------------------------------
  always_comb begin
    pst_d = pst_q;
    lock_d = lock_q;
    clkgd_d = 1'b0;
    idle_d = (bus_activity || host_q || power_q[UDR_PWR_SUSPEND_BIT]) ? 32'h0 : idle_q + 32'h1;
    case (pst_q)
      UDR_PH_OFF: begin
        lock_d = 5'h00;
        if (!phy_q[UDR_PHY_PDWN_BIT] && !phy_q[UDR_PHY_OTGPD_BIT] &&
            !phy_q[UDR_PHY_OSCPD_BIT] && phy_q[UDR_PHY_PLLON_BIT]) pst_d = UDR_PH_LOCK;
      end
      UDR_PH_LOCK: begin
        if (!phy_q[UDR_PHY_PLLON_BIT] || phy_q[UDR_PHY_PDWN_BIT]) pst_d = UDR_PH_OFF;
        else if (pll_locked && lock_q >= 5'(UDR_PLL_LOCK_CYC - 1)) pst_d = UDR_PH_GOOD;
        else lock_d = lock_q + 5'h1;
      end
      UDR_PH_GOOD: begin
        // R05 clock good
        clkgd_d = 1'b1;
        if (!phy_q[UDR_PHY_PLLON_BIT] || phy_q[UDR_PHY_PDWN_BIT] || !pll_locked) begin
          pst_d = UDR_PH_OFF;
          clkgd_d = 1'b0;
        end
      end
      default: pst_d = UDR_PH_OFF;
    endcase
    // R10 role from cable
    host_d = cable_a_end;
    // R06 vbus auto
    // R22 digital enable
    vbus_d = cable_a_end && session_valid;
    // R13 connect only when set
    pu_d = power_d[UDR_PWR_SOFTC_BIT] && !cable_a_end && clkgd_q;
    // R04 line swap
    swap_d = phy_q[UDR_PHY_POL_BIT];
    rsm_d = power_q[UDR_PWR_RESUME_BIT] && power_q[UDR_PWR_SUSPEND_BIT];
    // R19 fifo flush
    flush_d = bus_reset && !host_q && !bus_reset_q;
    irq_d = |(istat_d & ien_q);
    // ready flags kept as flops so the bus pins come straight from registers
    aw_rdy_d = !aw_d;
    w_rdy_d = !w_d;
    ar_rdy_d = !rv_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fnadr_q <= 7'h00; power_q <= 8'h00; index_q <= 4'h0; phy_q <= UDR_PHY_RESET;
      istat_q <= 16'h0000; ien_q <= 16'h0000; idle_q <= 32'h0; lock_q <= 5'h00;
      pst_q <= UDR_PH_OFF; clkgd_q <= 1'b0;
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      awa_q <= 12'h000; wd_q <= 32'h0; rd_q <= 32'h0; ws_q <= 4'h0;
      br_q <= 2'b00; rr_q <= 2'b00;
      vbus_q <= 1'b0; pu_q <= 1'b0; swap_q <= 1'b0; host_q <= 1'b0;
      rsm_q <= 1'b0; flush_q <= 1'b0; irq_q <= 1'b0; bus_reset_q <= 1'b0;
      aw_rdy_q <= 1'b1;
      w_rdy_q  <= 1'b1;
      ar_rdy_q <= 1'b1;
    end else begin
      fnadr_q <= fnadr_d; power_q <= power_d; index_q <= index_d; phy_q <= phy_d;
      istat_q <= istat_d; ien_q <= ien_d; idle_q <= idle_d; lock_q <= lock_d;
      pst_q <= pst_d; clkgd_q <= clkgd_d;
      aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
      awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d; ws_q <= ws_d;
      br_q <= br_d; rr_q <= rr_d;
      vbus_q <= vbus_d; pu_q <= pu_d; swap_q <= swap_d; host_q <= host_d;
      rsm_q <= rsm_d; flush_q <= flush_d; irq_q <= irq_d; bus_reset_q <= bus_reset;
      aw_rdy_q <= aw_rdy_d;
      w_rdy_q  <= w_rdy_d;
      ar_rdy_q <= ar_rdy_d;
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = w_rdy_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign vbus_supply_enable_output = vbus_q;
  assign pullup_enable = pu_q;
  assign line_swap     = swap_q;
  assign host_mode     = host_q;
  assign resume_drive  = rsm_q;
  assign fifo_flush    = flush_q;
  assign usb_irq       = irq_q;

endmodule : udr_link_ctrl

// File: src/udr_pkg.sv
package udr_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] UDR_FNADR_OFF     = 12'h000;
  localparam logic [11:0] UDR_POWER_OFF     = 12'h001;
  localparam logic [11:0] UDR_INTSTAT_OFF   = 12'h00C;
  localparam logic [11:0] UDR_INTEN_OFF     = 12'h010;
  localparam logic [11:0] UDR_INDEX_OFF     = 12'h00E;
  localparam logic [11:0] UDR_PHYCTL_OFF    = 12'h020;
  localparam logic [11:0] UDR_STATUS_OFF    = 12'h024;
  localparam logic [11:0] UDR_IDX_BASE      = 12'h410;
  localparam logic [11:0] UDR_IDX_LAST      = 12'h41F;
  localparam logic [11:0] UDR_FLAT_BASE     = 12'h500;
  localparam logic [11:0] UDR_FLAT_LAST     = 12'h54F;

  // ----------------------------------------------------------------
  // power register fields
  // ----------------------------------------------------------------
  localparam int UDR_PWR_SUSPEND_BIT = 1;
  localparam int UDR_PWR_RESUME_BIT  = 2;
  localparam int UDR_PWR_HSACT_BIT   = 4;
  localparam int UDR_PWR_HSEN_BIT    = 5;
  localparam int UDR_PWR_SOFTC_BIT   = 6;

  // ----------------------------------------------------------------
  // phy control fields
  // ----------------------------------------------------------------
  localparam int UDR_PHY_CLKSEL_BIT  = 0;
  localparam int UDR_PHY_POL_BIT     = 1;
  localparam int UDR_PHY_PDWN_BIT    = 2;
  localparam int UDR_PHY_OTGPD_BIT   = 3;
  localparam int UDR_PHY_OSCPD_BIT   = 4;
  localparam int UDR_PHY_SESEN_BIT   = 5;
  localparam int UDR_PHY_VBDET_BIT   = 6;
  localparam int UDR_PHY_PLLON_BIT   = 7;
  localparam int UDR_PHY_CLKGD_BIT   = 8;
  localparam logic [7:0] UDR_PHY_RESET = 8'h1C;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int UDR_INT_SUSPEND = 0;
  localparam int UDR_INT_RESUME  = 1;
  localparam int UDR_INT_RESET   = 2;
  localparam int UDR_INT_SOF     = 3;
  localparam int UDR_INT_CONN    = 4;
  localparam int UDR_INT_DISCON  = 5;
  localparam int UDR_INT_EP0     = 8;

  // ----------------------------------------------------------------
  // fifo ram and timing
  // ----------------------------------------------------------------
  localparam int          UDR_RAM_BYTES  = 4096;
  localparam logic [12:0] UDR_EP0_SIZE   = 13'h0040;
  localparam logic [12:0] UDR_EP0_START  = 13'h0000;
  localparam int          UDR_CLK_KHZ    = 40000;
  localparam int          UDR_SUSP_US    = 3000;
  localparam int          UDR_SUSP_CYC   = UDR_SUSP_US * (UDR_CLK_KHZ / 1000);
  localparam int          UDR_PLL_LOCK_CYC = 16;

  typedef enum logic [1:0] {UDR_PH_OFF, UDR_PH_LOCK, UDR_PH_GOOD} udr_phy_st_t;

endpackage : udr_pkg

// File: testbench/udr_bus_model.sv
// ----------------------------------------------------------------
// far side of the usb link: bus events seen by the block
// ----------------------------------------------------------------
module udr_bus_model (
  input  wire logic       aclk,
  output logic            bus_activity,
  output logic            bus_resume,
  output logic            bus_reset,
  output logic            bus_connect,
  output logic            bus_disconnect,
  output logic            bus_sof,
  output logic            hs_handshake_ok,
  output logic      [4:0] ep_done
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    bus_activity    = 1'b1;
    bus_resume      = 1'b0;
    bus_reset       = 1'b0;
    hs_handshake_ok = 1'b0;
    {ep_done, bus_disconnect, bus_connect, bus_sof} = 8'h00;
  end

  // traffic stops and stays stopped until wake
  task automatic quiet(input int n);
    @(posedge aclk);
    bus_activity <= 1'b0;
    repeat (n) @(posedge aclk);
  endtask : quiet

  // sig low: traffic returns without resume signalling
  // clock kept running
  task automatic wake(input logic sig);
    @(posedge aclk);
    bus_resume   <= sig;
    bus_activity <= 1'b1;
    repeat (4) @(posedge aclk);
    bus_resume <= 1'b0;
  endtask : wake

  task automatic reset_bus(input logic hs);
    @(posedge aclk);
    bus_reset <= 1'b1;
    hs_handshake_ok <= hs;
    repeat (8) @(posedge aclk);
    bus_reset       <= 1'b0;
    hs_handshake_ok <= 1'b0;
    @(posedge aclk);
  endtask : reset_bus

  // one-cycle event: 0 sof, 1 connect, 2 disconnect, 3..7 endpoint done
  task automatic ev(input int k);
    @(posedge aclk);
    {ep_done, bus_disconnect, bus_connect, bus_sof} <= 8'h01 << k;
    @(posedge aclk);
    {ep_done, bus_disconnect, bus_connect, bus_sof} <= 8'h00;
  endtask : ev
endmodule : udr_bus_model

// File: testbench/udr_link_ctrl_asserts.sv
// ----------------------------------------------------------------
// port checks for the link control block
// ----------------------------------------------------------------
module udr_link_ctrl_asserts #(
  parameter int SUSP_CYC = 20,
  parameter int NUM_EP   = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cable_a_end,
  input wire logic session_valid,
  input wire logic bus_reset,
  input wire logic vbus_supply_enable_output,
  input wire logic pullup_enable,
  input wire logic host_mode,
  input wire logic fifo_flush
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  vbus_on_a: assert property (
    cable_a_end && session_valid |=> vbus_supply_enable_output) else $error("vbus not raised");
  vbus_off_a: assert property (
    !cable_a_end |=> !vbus_supply_enable_output) else $error("vbus on as peripheral");
  host_role_a: assert property (
    cable_a_end [*3] |-> host_mode) else $error("host role not taken");
  conn_role_a: assert property (
    pullup_enable |-> !host_mode) else $error("pull-up on in host role");
  reset_idle_a: assert property (
    $rose(aresetn) |-> !pullup_enable && !fifo_flush) else $error("outputs busy after reset");
  flush_start_a: assert property (
    $rose(bus_reset) && !host_mode |-> ##[1:2] fifo_flush) else $error("no fifo flush");
  flush_pulse_a: assert property (
    fifo_flush |=> !fifo_flush) else $error("flush longer than one cycle");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid) else $error("no write response");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid) else $error("no read data");
  rd_close_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data not released");

  cover property (fifo_flush);
  cover property (vbus_supply_enable_output);
  cover property (pullup_enable);
endmodule : udr_link_ctrl_asserts

bind udr_link_ctrl udr_link_ctrl_asserts #(.SUSP_CYC(SUSP_CYC), .NUM_EP(NUM_EP)) u_chk (.*);

// File: testbench/udr_link_ctrl_tb_top.sv
// ----------------------------------------------------------------
// link control testbench
// ----------------------------------------------------------------
module udr_link_ctrl_tb_top
  import udr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] IDX_WORD = {UDR_INDEX_OFF[11:2], 2'b00};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        cable_a_end = 1'b0, session_valid = 1'b0, pll_locked = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_q, bresp_q;
  logic [31:0] s_axi_rdata, rd_q;
  logic        bus_activity, bus_resume, bus_reset, bus_connect, bus_disconnect, bus_sof;
  logic        hs_handshake_ok, vbus_supply_enable_output, pullup_enable, line_swap;
  logic        host_mode, resume_drive, fifo_flush, usb_irq;
  logic [4:0]  ep_done;
  int          mismatches = 0, checked = 0, cyc = 0;

  always #12.5 aclk = ~aclk;

  udr_link_ctrl #(.SUSP_CYC(20)) dut (.*);
  udr_bus_model bus (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bresp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rresp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask : rc

  task automatic t_phy;
    rc(UDR_PHYCTL_OFF, 32'h1FF, 32'h01C);
    wr(UDR_PHYCTL_OFF, 32'h0E3);
    pll_locked <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(line_swap, 1'b1);
    rd_q = 32'h0;
    for (int i = 0; i < 40 && !rd_q[8]; i++) rd(UDR_PHYCTL_OFF, rd_q);
    chk(rd_q & 32'h1FF, 32'h1E3);
    wr(UDR_PHYCTL_OFF, 32'h0E0);
    repeat (3) @(posedge aclk);
    chk(line_swap, 1'b0);
    wr(UDR_FNADR_OFF, 32'h4000);
    repeat (3) @(posedge aclk);
    chk(pullup_enable, 1'b1);
    wr(UDR_FNADR_OFF, 32'h0);
    repeat (3) @(posedge aclk);
    chk(pullup_enable, 1'b0);
  endtask : t_phy

  task automatic t_ep;
    for (int i = 1; i < 5; i++) begin
      wr(IDX_WORD, 32'(i << 16));
      wr(12'h418, 32'hA500 + i);
    end
    rc(12'h418, 32'hFFFFFFFF, 32'hA504);
    for (int i = 1; i < 5; i++) rc(12'h508 + 12'(16 * i), 32'hFFFFFFFF, 32'hA500 + i);
    wr(12'h50C, 32'hFFFFFFFF);
    chk(bresp_q, 2'b00);
    rc(12'h50C, 32'hFFFFFFFF, {3'h0, UDR_EP0_SIZE, 3'h0, UDR_EP0_START});
    rd(12'h550, rd_q);
    chk(rresp_q, 2'b10);
    chk(rd_q, 32'h0);
    wr(12'h550, 32'h1);
    chk(bresp_q, 2'b10);
  endtask : t_ep

  task automatic t_vbus;
    cable_a_end   <= 1'b1;
    session_valid <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(vbus_supply_enable_output, 1'b1);
    chk(host_mode, 1'b1);
    rc(UDR_STATUS_OFF, 32'h30000, 32'h30000);
    session_valid <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(vbus_supply_enable_output, 1'b0);
    cable_a_end   <= 1'b0;
    session_valid <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(vbus_supply_enable_output, 1'b0);
    chk(host_mode, 1'b0);
    session_valid <= 1'b0;
  endtask : t_vbus

  task automatic t_susp;
    wr(UDR_INTEN_OFF, 32'hFFFF);
    wr(UDR_STATUS_OFF, 32'hFFFF);
    bus.quiet(30);
    rc(UDR_STATUS_OFF, 32'h3, 32'h1);
    rc(UDR_FNADR_OFF, 32'h200, 32'h200);
    chk(usb_irq, 1'b1);
    bus.wake(1'b1);
    rc(UDR_STATUS_OFF, 32'h3, 32'h3);
    rc(UDR_FNADR_OFF, 32'h200, 32'h0);
    wr(UDR_STATUS_OFF, 32'hFFFF);
    bus.quiet(30);
    wr(UDR_FNADR_OFF, 32'h400);
    // hold kept short: resume_drive has no hold count, only the idle count is scaled down
    repeat (8) @(posedge aclk);
    chk(resume_drive, 1'b1);
    // host answers while the resume bit still stands
    bus.wake(1'b1);
    wr(UDR_FNADR_OFF, 32'h0);
    rc(UDR_STATUS_OFF, 32'h2, 32'h0);
    rc(UDR_FNADR_OFF, 32'h200, 32'h0);
  endtask : t_susp

  task automatic t_breset;
    for (int h = 0; h < 2; h++) begin
      wr(UDR_FNADR_OFF, 32'h5 | 32'(h << 13));
      wr(IDX_WORD, 32'h30000);
      wr(12'h410, 32'h5A5A);
      wr(UDR_STATUS_OFF, 32'hFFFF);
      bus.reset_bus(h[0]);
      rc(UDR_FNADR_OFF, 32'h107F, 32'(h << 12));
      rc(IDX_WORD, 32'hF0000, 32'h0);
      rc(12'h530, 32'hFFFFFFFF, 32'h0);
      rc(UDR_STATUS_OFF, 32'h4, 32'h4);
    end
  endtask : t_breset

  task automatic t_events;
    for (int k = 0; k < 8; k++) begin
      wr(UDR_STATUS_OFF, 32'hFFFF);
      bus.ev(k);
      rc(UDR_STATUS_OFF, 32'h1F38, 32'h1 << (k < 3 ? k + 3 : k + 5));
      chk(usb_irq, 1'b1);
    end
    wr(UDR_INTEN_OFF, 32'h0);
    repeat (3) @(posedge aclk);
    chk(usb_irq, 1'b0);
  endtask : t_events

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // ceiling well above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_phy();
    $display("phy and connect test done");
    t_ep();
    $display("endpoint window test done");
    t_vbus();
    $display("vbus and role test done");
    t_susp();
    $display("suspend test done");
    t_breset();
    $display("bus reset test done");
    t_events();
    $display("event test done");
    end_sim();
  end
endmodule : udr_link_ctrl_tb_top
